// File: include/tx_dac_map.vh
// Register offsets, field positions, reset values and timing figures
`ifndef TX_DAC_MAP_VH
`define TX_DAC_MAP_VH

// ==========================================================
// Clock and timing figures
// ==========================================================
`define CLK_KHZ 125000
`define INIT_DELAY_MS 20
`define QT_SLOT_NS 1600
`define NS_PER_US 1000
`define US_PER_MS 1000

// ==========================================================
// Register offsets
// ==========================================================
`define OFS_STATUS 8'h6E
`define OFS_QT_WAIT 8'h88
`define OFS_POLARITY 8'hC6

// ==========================================================
// Reset values
// ==========================================================
`define RST_SOFT_DIS 2'h0
`define RST_QT_WAIT 2'h3
`define RST_POLARITY 4'h0

// ==========================================================
// Status byte fields
// ==========================================================
`define ST_SOFT_A 0
`define ST_SOFT_B 1
`define ST_PIN_A 2
`define ST_PIN_B 3
`define ST_EXIT_A 4
`define ST_EXIT_B 5
`define ST_FAULT 6
`define ST_NOT_RDY 7

// ==========================================================
// Quick-trip slot order
// ==========================================================
`define QT_BIAS_HI_A 3'h0
`define QT_PWR_LO_A 3'h1
`define QT_PWR_HI_A 3'h2
`define QT_BIAS_HI_B 3'h3
`define QT_PWR_LO_B 3'h4
`define QT_PWR_HI_B 3'h5
`define QT_COUNT 6

`endif

// File: verilog/pin_sync3.v
// Three-stage synchroniser with agreement filter for pin inputs
`timescale 1ns/10ps
module pin_sync3 #(
   parameter W = 1
) (
   input wire clk_sys, // System clock
   input wire rst_n, // Asynchronous reset, active low
   input wire ce, // Clock enable
   input wire [W-1:0] pin_in, // Asynchronous pin levels
   output reg [W-1:0] level_r // Filtered synchronous levels
);
   reg [W-1:0] s1_r;
   reg [W-1:0] s2_r;
   reg [W-1:0] s3_r;
   integer i;

   // ==========================================================
   // Sync chain; only the second and third stages are compared
   // ==========================================================
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= {W{1'b0}};
         s2_r <= {W{1'b0}};
         s3_r <= {W{1'b0}};
         level_r <= {W{1'b0}};
      end else if (ce) begin
         s1_r <= pin_in;
         s2_r <= s1_r;
         s3_r <= s2_r;
         // A bit changes only once two late stages agree
         for (i = 0; i < W; i = i + 1) begin
            if (s2_r[i] == s3_r[i]) begin
               level_r[i] <= s3_r[i];
            end
         end
      end
   end
endmodule

// File: verilog/tx_dac_sequencer.v
// DAC sequencing, transmit disable and shared quick-trip comparator
// Behaviour
// R1 - DACs high impedance until init delay ends
// R2 - After init delay drive nonvolatile initial codes
// R3 - Load LUT after temp, supply check if enabled
// R4 - Fault restart by toggling both disables, no delay
// R5 - Disable input high turns transmitter outputs off
// R6 - Disable low reloads present-temperature codes
// R7 - Software disable bit acts like the pin
// R8 - Per-DAC off level: reference or zero
// R9 - One comparator shared by six checks
// R10 - Fixed slot order, power and bias thresholds
// R11 - Each comparison sets or clears its alarm
// R12 - One full polling cycle before acting
// R13 - Low-power trip waits for exit interval
// R14 - High trips wait unless configured otherwise
// R15 - Monitor values compared as unsigned codes
// R16 - Init delay is about 20 ms
// R17 - Each comparison slot lasts 1.6 us
// R18 - Trips reach shutdown only through masks
// R19 - Trips drive fault output unmasked
// R20 - Effective disable is pin OR software bit
// R21 - Exit flag after reload releases deferred trips
`timescale 1ns/10ps
`include "tx_dac_map.vh"
module tx_dac_sequencer #(
   parameter INIT_CYCLES = `INIT_DELAY_MS * `CLK_KHZ, // [R16]
   parameter SLOT_CYCLES = `QT_SLOT_NS * `CLK_KHZ / `NS_PER_US
      / `US_PER_MS, // [R17]
   parameter DW = 10,
   parameter TW = 8
) (
   input wire clk_sys, // System clock, 125 MHz
   input wire rst_n, // Asynchronous reset, active low
   input wire ce, // Clock enable, freezes all state when low
   input wire tx_disable_in_a, // Disable pin, transmitter A
   input wire tx_disable_in_b, // Disable pin, transmitter B
   input wire temp_conv_done, // Pulse: temperature conversion done
   input wire vcc_conv_done, // Pulse: supply conversion done
   input wire vcc_above_low, // Supply above low alarm level
   input wire supply_low_alarm_en, // Supply-low alarm enabled
   input wire [4*DW-1:0] nv_init_code, // Initial codes from NV memory
   input wire [4*DW-1:0] lut_code, // Codes for present temperature
   input wire [TW-1:0] power_monitor_in_a, // Power monitor A
   input wire [TW-1:0] power_monitor_in_b, // Power monitor B
   input wire [TW-1:0] bias_monitor_in_a, // Bias monitor A
   input wire [TW-1:0] bias_monitor_in_b, // Bias monitor B
   input wire [TW-1:0] power_high_threshold_a, // High power level A
   input wire [TW-1:0] power_high_threshold_b, // High power level B
   input wire [TW-1:0] power_low_threshold_a, // Low power level A
   input wire [TW-1:0] power_low_threshold_b, // Low power level B
   input wire [TW-1:0] bias_high_threshold_a, // High bias level A
   input wire [TW-1:0] bias_high_threshold_b, // High bias level B
   input wire [`QT_COUNT-1:0] qt_shutdown_mask, // 1 lets trip shut down
   input wire [7:0] reg_addr, // Register byte address
   input wire [7:0] reg_wdata, // Register write data
   input wire reg_we, // Register write strobe
   output reg [7:0] reg_rdata, // Read data of addressed register
   output reg [4*DW-1:0] dac_code, // Codes to the four DACs, MOD and APC per transmitter
   output reg [3:0] dac_oe, // 0 keeps a DAC in high impedance
   output reg tx_disable_out_a, // Disable to laser driver A
   output reg tx_disable_out_b, // Disable to laser driver B
   output reg tx_fault_out, // Transmit fault, high = fault
   output reg shutdown_trigger, // Latched shutdown
   output reg [1:0] disable_exit_interval, // Exit interval ended
   output reg [`QT_COUNT-1:0] qt_alarm // Quick-trip alarm bits
);
   // ==========================================================
   // Declarations
   // ==========================================================
   localparam [4:0] S_HIZ = 5'b00001;
   localparam [4:0] S_NVINIT = 5'b00010;
   localparam [4:0] S_VCCWAIT = 5'b00100;
   localparam [4:0] S_RUN = 5'b01000;
   localparam [4:0] S_RESTART = 5'b10000;
   localparam [2:0] QT_LAST = `QT_PWR_HI_B;

   reg [4:0] state_r;
   reg [4:0] state_nxt;
   reg [31:0] init_cnt_r;
   reg [31:0] slot_cnt_r;
   reg [2:0] qt_idx_r;
   reg qt_armed_r;
   reg [1:0] soft_dis_r;
   reg [1:0] qt_wait_r;
   reg [3:0] polarity_r;
   reg [1:0] off_q_r;
   reg [1:0] both_hi_seen_r;
   reg [TW-1:0] cmp_mon;
   reg [TW-1:0] cmp_thr;
   reg cmp_low;
   reg cmp_hit;
   reg [`QT_COUNT-1:0] gate;
   reg [4*DW-1:0] code_nxt;
   reg [7:0] rdata_nxt;
   integer k;

   wire [1:0] pin_dis;
   wire [1:0] eff_dis;
   wire [1:0] tx_off;
   wire slot_end;
   wire trip_now;
   wire restart_go;

   // ==========================================================
   // Pin synchronisers
   // ==========================================================
   pin_sync3 #(.W(2)) u_dis_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .ce(ce),
      .pin_in({tx_disable_in_b, tx_disable_in_a}),
      .level_r(pin_dis)
   );

   // Pin or software bit disables a transmitter
   assign eff_dis = pin_dis | soft_dis_r; // [R20] [R7]
   // Latched shutdown also turns both transmitters off
   assign tx_off = eff_dis | {2{shutdown_trigger}}; // [R5]
   assign slot_end = (slot_cnt_r == SLOT_CYCLES - 1);
   // Restart once both disables were high and are now low
   assign restart_go = shutdown_trigger & (&both_hi_seen_r)
      & ~eff_dis[0] & ~eff_dis[1]; // [R4]

   // ==========================================================
   // Power-up sequence
   // ==========================================================
   always @* begin
      state_nxt = state_r;
      case (state_r)
         S_HIZ: begin
            if (init_cnt_r == INIT_CYCLES - 1) begin
               state_nxt = S_NVINIT; // [R1] [R2]
            end
         end
         S_NVINIT: begin
            // Temperature must be known before LUT codes apply
            if (temp_conv_done) begin
               state_nxt = supply_low_alarm_en ? S_VCCWAIT : S_RUN; // [R3]
            end
         end
         S_VCCWAIT: begin
            if (vcc_conv_done && vcc_above_low) begin
               state_nxt = S_RUN; // [R3]
            end
         end
         S_RUN: begin
            if (restart_go) begin
               state_nxt = S_RESTART; // [R4]
            end
         end
         S_RESTART: begin
            // Temperature already known, so no init delay here
            state_nxt = supply_low_alarm_en ? S_VCCWAIT : S_RUN; // [R4]
         end
         default: begin
            state_nxt = S_HIZ;
         end
      endcase
   end

   // State register and init delay counter
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= S_HIZ;
         init_cnt_r <= 32'h0000_0000;
      end else if (ce) begin
         state_r <= state_nxt;
         if (state_r == S_HIZ) begin
            init_cnt_r <= init_cnt_r + 32'h0000_0001; // [R16]
         end
      end
   end

   // ==========================================================
   // DAC code selection
   // ==========================================================
   // Off level per DAC: all ones gives the reference, zero 0V.
   // DAC order: MOD A, APC A, MOD B, APC B.
   always @* begin
      code_nxt = {4*DW{1'b0}};
      for (k = 0; k < 4; k = k + 1) begin
         if (state_r == S_HIZ) begin
            code_nxt[k*DW +: DW] = {DW{1'b0}};
         end else if (tx_off[k/2]) begin
            code_nxt[k*DW +: DW] = {DW{polarity_r[k]}}; // [R8] [R5]
         end else if (state_r == S_RUN) begin
            code_nxt[k*DW +: DW] = lut_code[k*DW +: DW]; // [R3] [R6]
         end else begin
            code_nxt[k*DW +: DW] = nv_init_code[k*DW +: DW]; // [R2]
         end
      end
   end

   // DAC outputs, disable outputs and exit interval flags
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         dac_code <= {4*DW{1'b0}};
         dac_oe <= 4'h0;
         tx_disable_out_a <= 1'b1;
         tx_disable_out_b <= 1'b1;
         off_q_r <= 2'h3;
         disable_exit_interval <= 2'h0;
         both_hi_seen_r <= 2'h0;
      end else if (ce) begin
         dac_code <= code_nxt;
         dac_oe <= {4{state_r != S_HIZ}}; // [R1]
         tx_disable_out_a <= tx_off[0]; // [R5]
         tx_disable_out_b <= tx_off[1]; // [R5]
         off_q_r <= tx_off;
         // Flag rises one cycle after the LUT reload was driven
         disable_exit_interval <= {2{state_r == S_RUN}} & ~tx_off
            & ~off_q_r; // [R21]
         // Track the toggle of both disables during a fault
         if (!shutdown_trigger) begin
            both_hi_seen_r <= 2'h0;
         end else begin
            both_hi_seen_r <= both_hi_seen_r | eff_dis; // [R4]
         end
      end
   end

   // ==========================================================
   // Shared quick-trip comparator
   // ==========================================================
   // One comparator; operands steered by the slot index
   always @* begin
      cmp_low = 1'b0;
      case (qt_idx_r)
         `QT_BIAS_HI_A: begin
            cmp_mon = bias_monitor_in_a;
            cmp_thr = bias_high_threshold_a; // [R10]
         end
         `QT_PWR_LO_A: begin
            cmp_mon = power_monitor_in_a;
            cmp_thr = power_low_threshold_a;
            cmp_low = 1'b1;
         end
         `QT_PWR_HI_A: begin
            cmp_mon = power_monitor_in_a;
            cmp_thr = power_high_threshold_a;
         end
         `QT_BIAS_HI_B: begin
            cmp_mon = bias_monitor_in_b;
            cmp_thr = bias_high_threshold_b;
         end
         `QT_PWR_LO_B: begin
            cmp_mon = power_monitor_in_b;
            cmp_thr = power_low_threshold_b;
            cmp_low = 1'b1;
         end
         `QT_PWR_HI_B: begin
            cmp_mon = power_monitor_in_b;
            cmp_thr = power_high_threshold_b;
         end
         default: begin
            cmp_mon = {TW{1'b0}};
            cmp_thr = {TW{1'b0}};
         end
      endcase
      // Unsigned compare; monitor codes are straight binary
      cmp_hit = cmp_low ? (cmp_mon < cmp_thr)
         : (cmp_mon > cmp_thr); // [R9] [R15]
   end

   // Slot timer, index walk and alarm update
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         slot_cnt_r <= 32'h0000_0000;
         qt_idx_r <= `QT_BIAS_HI_A;
         qt_armed_r <= 1'b0;
         qt_alarm <= {`QT_COUNT{1'b0}};
      end else if (ce) begin
         if (slot_end) begin
            slot_cnt_r <= 32'h0000_0000;
            if (qt_idx_r == QT_LAST) begin
               qt_idx_r <= `QT_BIAS_HI_A; // [R10]
               qt_armed_r <= 1'b1; // [R12]
            end else begin
               qt_idx_r <= qt_idx_r + 3'h1;
            end
            // First lap only settles the comparator
            if (qt_armed_r) begin
               qt_alarm[qt_idx_r] <= cmp_hit; // [R11]
            end
         end else begin
            slot_cnt_r <= slot_cnt_r + 32'h0000_0001; // [R17]
         end
      end
   end

   // ==========================================================
   // Trip gating, shutdown and fault output
   // ==========================================================
   // Low trips always wait; high trips wait if configured
   always @* begin
      gate[`QT_BIAS_HI_A] = ~qt_wait_r[0] | disable_exit_interval[0];
      gate[`QT_PWR_LO_A] = disable_exit_interval[0]; // [R13]
      gate[`QT_PWR_HI_A] = ~qt_wait_r[0] | disable_exit_interval[0];
      gate[`QT_BIAS_HI_B] = ~qt_wait_r[1] | disable_exit_interval[1];
      gate[`QT_PWR_LO_B] = disable_exit_interval[1]; // [R13]
      gate[`QT_PWR_HI_B] = ~qt_wait_r[1] | disable_exit_interval[1];
   end

   assign trip_now = |(qt_alarm & qt_shutdown_mask & gate); // [R18] [R14]

   // Shutdown latches until both disables are toggled
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         shutdown_trigger <= 1'b0;
         tx_fault_out <= 1'b0;
      end else if (ce) begin
         if (trip_now) begin
            shutdown_trigger <= 1'b1; // [R18] [R21]
         end else if (state_r == S_RESTART) begin
            shutdown_trigger <= 1'b0; // [R4]
         end
         // Unmasked: any trip shows on the fault pin
         tx_fault_out <= |qt_alarm; // [R19]
      end
   end

   // ==========================================================
   // Registers
   // ==========================================================
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         soft_dis_r <= `RST_SOFT_DIS;
         qt_wait_r <= `RST_QT_WAIT;
         polarity_r <= `RST_POLARITY;
      end else if (ce && reg_we) begin
         case (reg_addr)
            `OFS_STATUS: begin
               soft_dis_r <= {reg_wdata[`ST_SOFT_B],
                  reg_wdata[`ST_SOFT_A]}; // [R7]
            end
            `OFS_QT_WAIT: begin
               qt_wait_r <= reg_wdata[1:0]; // [R14]
            end
            `OFS_POLARITY: begin
               polarity_r <= reg_wdata[3:0]; // [R8]
            end
            default: begin
               soft_dis_r <= soft_dis_r;
            end
         endcase
      end
   end

   // Read mux; unmapped addresses and reserved bits read zero
   always @* begin
      rdata_nxt = 8'h00;
      case (reg_addr)
         `OFS_STATUS: begin
            rdata_nxt[`ST_SOFT_A] = soft_dis_r[0];
            rdata_nxt[`ST_SOFT_B] = soft_dis_r[1];
            rdata_nxt[`ST_PIN_A] = pin_dis[0];
            rdata_nxt[`ST_PIN_B] = pin_dis[1];
            rdata_nxt[`ST_EXIT_A] = disable_exit_interval[0];
            rdata_nxt[`ST_EXIT_B] = disable_exit_interval[1];
            rdata_nxt[`ST_FAULT] = shutdown_trigger;
            rdata_nxt[`ST_NOT_RDY] = (state_r == S_HIZ);
         end
         `OFS_QT_WAIT: begin
            rdata_nxt[1:0] = qt_wait_r;
         end
         `OFS_POLARITY: begin
            rdata_nxt[3:0] = polarity_r;
         end
         default: begin
            rdata_nxt = 8'h00;
         end
      endcase
   end

   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (ce) begin
         reg_rdata <= rdata_nxt;
      end
   end
endmodule

// File: tb/laser_drv_model.sv
// Behavioural model of the two laser drivers feeding the monitor inputs
`timescale 1ns/10ps
module laser_drv_model (
   input wire logic clk_sys, // System clock
   input wire logic tx_disable_out_a, // Disable from device, driver A
   input wire logic tx_disable_out_b, // Disable from device, driver B
   input wire logic [7:0] pwr_set_a, // Optical power while lasing, A
   input wire logic [7:0] pwr_set_b, // Optical power while lasing, B
   input wire logic [7:0] bias_set_a, // Bias level while lasing, A
   input wire logic [7:0] bias_set_b, // Bias level while lasing, B
   output logic [7:0] power_monitor_in_a, // Power monitor, A
   output logic [7:0] power_monitor_in_b, // Power monitor, B
   output logic [7:0] bias_monitor_in_a, // Bias monitor, A
   output logic [7:0] bias_monitor_in_b // Bias monitor, B
);
   // ==========================================================
   // Monitors
   // ==========================================================
   // Start dark so nothing is unknown before the first edge
   initial begin
      power_monitor_in_a = 8'h00;
      power_monitor_in_b = 8'h00;
      bias_monitor_in_a = 8'h00;
      bias_monitor_in_b = 8'h00;
   end
   // A disabled laser emits nothing and draws no bias
   always @(posedge clk_sys) begin
      power_monitor_in_a <= tx_disable_out_a ? 8'h00 : pwr_set_a;
      power_monitor_in_b <= tx_disable_out_b ? 8'h00 : pwr_set_b;
      bias_monitor_in_a <= tx_disable_out_a ? 8'h00 : bias_set_a;
      bias_monitor_in_b <= tx_disable_out_b ? 8'h00 : bias_set_b;
   end
endmodule

// File: tb/tx_dac_sequencer_chk.sv
// Port-level assertion checker for the DAC sequencer
`timescale 1ns/10ps
module tx_dac_sequencer_chk #(
   parameter INIT_CYCLES = 2500000,
   parameter SLOT_CYCLES = 200,
   parameter DW = 10
) (
   input wire clk_sys, // System clock
   input wire rst_n, // Reset, active low
   input wire tx_disable_in_a, // Disable pin A
   input wire [4*DW-1:0] nv_init_code, // Initial codes
   input wire [5:0] qt_shutdown_mask, // Shutdown masks
   input wire [7:0] reg_addr, // Register address
   input wire [7:0] reg_wdata, // Register write data
   input wire reg_we, // Register write strobe
   input wire [4*DW-1:0] dac_code, // DAC codes
   input wire [3:0] dac_oe, // DAC output enables
   input wire tx_disable_out_a, // Driver disable A
   input wire tx_fault_out, // Fault output
   input wire shutdown_trigger, // Latched shutdown
   input wire [1:0] disable_exit_interval, // Exit flags
   input wire [5:0] qt_alarm // Quick-trip alarms
);
   reg [31:0] cnt_r;
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   // ==========================================================
   // Cycles since reset, saturating
   // ==========================================================
   always @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) cnt_r <= 32'h0000_0000;
      else if (cnt_r != 32'hFFFF_FFFF) cnt_r <= cnt_r + 32'h0000_0001;
   end
   // Pin held long enough to pass the synchroniser
   sequence s_pin_up;
      $rose(tx_disable_in_a) ##1 tx_disable_in_a [*5];
   endsequence
   // Transmitter A released in normal running, not a restart
   sequence s_release;
      $fell(tx_disable_out_a) && dac_oe[0] && !$past(shutdown_trigger, 2);
   endsequence
   AST_HIZ_INIT: assert property (
      cnt_r < INIT_CYCLES - 1 |-> dac_oe == 4'h0)
      else $error("DAC enabled during init delay");
   AST_NV_FIRST: assert property (
      $rose(dac_oe[0]) |->
      dac_code == nv_init_code && cnt_r >= INIT_CYCLES - 1)
      else $error("first DAC codes not the initial codes");
   AST_PIN_OFF: assert property (
      s_pin_up |-> ##[0:1] tx_disable_out_a)
      else $error("disable pin did not turn transmitter off");
   AST_SOFT_OFF: assert property (
      reg_we && reg_addr == 8'h6E && reg_wdata[0] |-> ##2 tx_disable_out_a)
      else $error("soft disable did not turn transmitter off");
   AST_OFF_LEVEL: assert property (
      tx_disable_out_a && $past(tx_disable_out_a) && dac_oe[0]
      |-> dac_code[9:0] inside {10'h000, 10'h3FF})
      else $error("off level neither zero nor reference");
   AST_FIRST_LAP: assert property (
      cnt_r < 6 * SLOT_CYCLES |-> qt_alarm == 6'h00)
      else $error("alarm acted on during first lap");
   AST_MASKED: assert property (
      $rose(shutdown_trigger) |->
      |($past(qt_alarm) & $past(qt_shutdown_mask)))
      else $error("shutdown without an unmasked trip");
   AST_FAULT: assert property (
      1'b1 |=> tx_fault_out == $past(|qt_alarm))
      else $error("fault output not the OR of alarms");
   AST_EXIT: assert property (
      s_release |-> ##[1:2] disable_exit_interval[0])
      else $error("exit flag missing after release");
endmodule
bind tx_dac_sequencer tx_dac_sequencer_chk #(.INIT_CYCLES(INIT_CYCLES),
   .SLOT_CYCLES(SLOT_CYCLES), .DW(DW)) u_chk (.*);

// File: tb/tx_dac_sequencer_tb.sv
// Self-checking testbench for the DAC sequencer
`timescale 1ns/10ps
module tx_dac_sequencer_tb;
   reg clk_sys = 1'b0;
   reg rst_n = 1'b0;
   reg ce = 1'b1;
   reg tx_disable_in_a = 1'b0, tx_disable_in_b = 1'b0;
   reg temp_conv_done = 1'b0, vcc_conv_done = 1'b0, vcc_above_low = 1'b0;
   reg supply_low_alarm_en = 1'b1;
   reg [39:0] nv_init_code = 40'h1122334455;
   reg [39:0] lut_code = 40'h66778899AA;
   reg [7:0] power_high_threshold_a = 8'hC0, power_high_threshold_b = 8'hC0;
   reg [7:0] power_low_threshold_a = 8'h40, power_low_threshold_b = 8'h40;
   reg [7:0] bias_high_threshold_a = 8'hA0, bias_high_threshold_b = 8'hA0;
   reg [5:0] qt_shutdown_mask = 6'h00;
   reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
   reg reg_we = 1'b0;
   reg [7:0] pwr_set_a = 8'h80, pwr_set_b = 8'h80;
   reg [7:0] bias_set_a = 8'h50, bias_set_b = 8'h50;
   wire [7:0] reg_rdata, power_monitor_in_a, power_monitor_in_b;
   wire [7:0] bias_monitor_in_a, bias_monitor_in_b;
   wire [39:0] dac_code;
   wire [3:0] dac_oe;
   wire tx_disable_out_a, tx_disable_out_b, tx_fault_out, shutdown_trigger;
   wire [1:0] disable_exit_interval;
   wire [5:0] qt_alarm;
   integer fail_count = 0, n_checks = 0, i;
   reg [37:0] rows [0:5];

   always #4 clk_sys = ~clk_sys;
   tx_dac_sequencer #(.INIT_CYCLES(50), .SLOT_CYCLES(4)) uut (.*);
   laser_drv_model drv (.*);

   // ==========================================================
   // Helpers
   // ==========================================================
   task step(input integer n);
      begin
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask
   task chk(input [39:0] got, input [39:0] exp);
      begin
         n_checks = n_checks + 1;
         if (got !== exp) begin
            fail_count = fail_count + 1;
            $display("BAD %0t seen %h expected %h", $time, got, exp);
         end
      end
   endtask
   // Byte write, strobe dropped for one edge between writes
   task wr(input [7:0] a, input [7:0] d);
      begin
         reg_addr = a;
         reg_wdata = d;
         reg_we = 1'b1;
         step(1);
         reg_we = 1'b0;
         step(1);
      end
   endtask
   // Read data lands one edge after the address
   task rdchk(input [7:0] a, input [7:0] m, input [7:0] e);
      begin
         reg_addr = a;
         step(1);
         chk(reg_rdata & m, e);
      end
   endtask
   task conv(input t, input v);
      begin
         temp_conv_done = t;
         vcc_conv_done = v;
         step(1);
         temp_conv_done = 1'b0;
         vcc_conv_done = 1'b0;
         step(3);
      end
   endtask
   task conclude;
      begin
         $display("checks %0d mismatches %0d", n_checks, fail_count);
         if (fail_count == 0 && n_checks > 0) $display("DONE - PASS");
         else $display("DONE - FAIL");
         $finish;
      end
   endtask
   // Hang guard
   initial begin
      #100000;
      fail_count = fail_count + 1;
      conclude;
   end

   // ==========================================================
   // Main sequence
   // ==========================================================
   initial begin
      // Row: power A, bias A, power B, bias B, expected alarms
      rows[0] = {8'hD0, 8'h50, 8'h80, 8'h50, 6'h04};
      rows[1] = {8'h20, 8'h50, 8'h80, 8'h50, 6'h02};
      rows[2] = {8'h80, 8'hF0, 8'h80, 8'h50, 6'h01};
      rows[3] = {8'h80, 8'h50, 8'hD0, 8'hF0, 6'h28};
      rows[4] = {8'h80, 8'h50, 8'h10, 8'h50, 6'h10};
      rows[5] = {8'h80, 8'h50, 8'h80, 8'h50, 6'h00};
      step(5);
      chk(dac_oe, 4'h0);
      chk(tx_disable_out_a, 1'b1);
      rst_n = 1'b1;
      step(40);
      chk(dac_oe, 4'h0);
      rdchk(8'h6E, 8'h80, 8'h80);
      rdchk(8'h88, 8'hFF, 8'h03);
      rdchk(8'hC6, 8'hFF, 8'h00);
      rdchk(8'h10, 8'hFF, 8'h00);
      for (i = 0; i < 100 && dac_oe !== 4'hF; i = i + 1) step(1);
      if (dac_oe !== 4'hF) begin
         fail_count = fail_count + 1;
         conclude;
      end
      chk(dac_code, nv_init_code);
      // Supply must be seen above its low level before the table codes
      conv(1'b1, 1'b0);
      chk(dac_code, nv_init_code);
      conv(1'b0, 1'b1);
      chk(dac_code, nv_init_code);
      vcc_above_low = 1'b1;
      conv(1'b0, 1'b1);
      chk(dac_code, lut_code);
      // Pin disable of A, mixed off levels, low trip held back
      wr(8'hC6, 8'h05);
      qt_shutdown_mask = 6'h02;
      tx_disable_in_a = 1'b1;
      step(8);
      chk(dac_code, {lut_code[39:20], 10'h000, 10'h3FF});
      chk(disable_exit_interval[0], 1'b0);
      step(56);
      chk(qt_alarm[1], 1'b1);
      chk(shutdown_trigger, 1'b0);
      qt_shutdown_mask = 6'h00;
      tx_disable_in_a = 1'b0;
      step(8);
      chk(dac_code, lut_code);
      chk(disable_exit_interval[0], 1'b1);
      // Software disable of B
      wr(8'h6E, 8'h02);
      chk(dac_code[39:20], {10'h000, 10'h3FF});
      chk(tx_disable_out_b, 1'b1);
      rdchk(8'h6E, 8'h03, 8'h02);
      // Swap to software disable of A, then release both
      wr(8'h6E, 8'h01);
      chk(tx_disable_out_a, 1'b1);
      chk(tx_disable_out_b, 1'b0);
      wr(8'h6E, 8'h00);
      step(2);
      chk(dac_code, lut_code);
      // Quick-trip table, masks closed
      for (i = 0; i < 6; i = i + 1) begin
         {pwr_set_a, bias_set_a, pwr_set_b, bias_set_b} = rows[i][37:6];
         step(56);
         chk(qt_alarm, rows[i][5:0]);
         chk(tx_fault_out, |rows[i][5:0]);
         chk(shutdown_trigger, 1'b0);
      end
      // Unmasked high power trip latches shutdown
      qt_shutdown_mask = 6'h04;
      pwr_set_a = 8'hD0;
      step(56);
      chk(shutdown_trigger, 1'b1);
      rdchk(8'h6E, 8'h40, 8'h40);
      qt_shutdown_mask = 6'h00;
      pwr_set_a = 8'h80;
      supply_low_alarm_en = 1'b0;
      step(56);
      chk(shutdown_trigger, 1'b1);
      // Restart by toggling both disables, no init delay again
      tx_disable_in_a = 1'b1;
      tx_disable_in_b = 1'b1;
      step(10);
      tx_disable_in_a = 1'b0;
      tx_disable_in_b = 1'b0;
      step(20);
      chk(shutdown_trigger, 1'b0);
      chk(dac_oe, 4'hF);
      chk(dac_code, lut_code);
      conclude;
   end
endmodule
